// File: design/rvpa_pkg.sv
package rvpa_pkg;
  // ***************************************************
  // Timing
  // ***************************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned LOOP_MS = 10;
  localparam int unsigned LOOP_CYC = LOOP_MS * (CLK_HZ / 1000);
  localparam logic [3:0] WD_TICKS = 4'h3;
  // ***************************************************
  // Register offsets
  // ***************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SETPT = 8'h04;
  localparam logic [7:0] OFS_PART = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_SERVO = 8'h10;
  localparam logic [7:0] OFS_SHARE = 8'h14;
  localparam logic [7:0] OFS_TRACK = 8'h18;
  localparam logic [7:0] OFS_RATE = 8'h1c;
  localparam logic [7:0] OFS_ISTAT = 8'h20;
  localparam logic [7:0] OFS_IMASK = 8'h24;
  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int CTRL_FORCE = 0;
  localparam int PB_ALIVE = 0;
  localparam int PB_PRI = 1;
  localparam int PB_OK = 2;
  localparam int ST_PRI = 0;
  localparam int ST_OK = 1;
  localparam int ST_HALT = 2;
  localparam int ST_SERWD = 3;
  localparam int ST_BUSWD = 4;
  localparam int ST_PFAIL = 5;
  localparam int ST_COIL = 6;
  localparam int ST_FBF = 7;
  localparam int ST_LOCAL = 8;
  localparam int IRQ_ROLE = 0;
  localparam int IRQ_PFAIL = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_HALT = 3;
  // ***************************************************
  // Reset values and codes
  // ***************************************************
  localparam logic [15:0] SETPT_RST = 16'h0000;
  localparam logic [7:0] SHARE_RST = 8'h0a;
  localparam logic [7:0] TRACK_RST = 8'h01;
  localparam logic [15:0] RATE_RST = 16'h0800;
  localparam logic [3:0] IMASK_RST = 4'h0;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] IDX_BAD = 4'hf;
  typedef enum logic {ROLE_BACKUP, ROLE_PRIMARY} rvpa_role_t;
endpackage

// File: design/rvpa_top.sv
// Design decisions made here: register access over AXI4-Lite and the register addresses.
module rvpa_top #(
  parameter int unsigned LOOP_CYC = rvpa_pkg::LOOP_CYC
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic local_mode_pin,
  input wire logic local_sp_valid,
  input wire logic [15:0] local_sp,
  input wire logic [5:0] diag_fail,
  input wire logic coil_fault,
  input wire logic [15:0] sec_a,
  input wire logic [15:0] sec_b,
  input wire logic [15:0] fb_pos,
  input wire logic [15:0] pi_out,
  input wire logic link_rx_valid,
  input wire logic link_rx_primary,
  input wire logic link_rx_ok,
  input wire logic [15:0] link_rx_servo,
  input wire logic [15:0] link_rx_fb,
  output logic link_tx_valid,
  output logic link_tx_primary,
  output logic link_tx_ok,
  output logic [15:0] link_tx_servo,
  output logic [15:0] link_tx_fb,
  output logic pi_run,
  output logic [15:0] setpoint,
  output logic [15:0] servo_out,
  output logic servo_en,
  output logic irq
);
  // ***************************************************
  // Helpers
  // ***************************************************
  // Offset to register index
  function automatic logic [3:0] dec(input logic [7:0] a);
    unique case (a)
      rvpa_pkg::OFS_CTRL: dec = 4'h0;
      rvpa_pkg::OFS_SETPT: dec = 4'h1;
      rvpa_pkg::OFS_PART: dec = 4'h2;
      rvpa_pkg::OFS_STAT: dec = 4'h3;
      rvpa_pkg::OFS_SERVO: dec = 4'h4;
      rvpa_pkg::OFS_SHARE: dec = 4'h5;
      rvpa_pkg::OFS_TRACK: dec = 4'h6;
      rvpa_pkg::OFS_RATE: dec = 4'h7;
      rvpa_pkg::OFS_ISTAT: dec = 4'h8;
      rvpa_pkg::OFS_IMASK: dec = 4'h9;
      default: dec = rvpa_pkg::IDX_BAD;
    endcase
  endfunction

  // Byte-enable merge
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        merge[8*i +: 8] = d[8*i +: 8];
      end
    end
  endfunction

  // Magnitude of a difference
  function automatic logic [15:0] absdiff(input logic [15:0] x, input logic [15:0] y);
    absdiff = (x > y) ? x - y : y - x;
  endfunction

  // ***************************************************
  // Reset and pin synchronisers
  // ***************************************************
  logic rst_m_r, rst_n;
  logic loc_m_r, loc_r;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_m_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n <= rst_m_r;
    end
  end

  // Local mode pin sync
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      loc_m_r <= 1'b0;
      loc_r <= 1'b0;
    end else begin
      loc_m_r <= local_mode_pin;
      loc_r <= loc_m_r;
    end
  end

  // ***************************************************
  // AXI4-Lite slave
  // ***************************************************
  logic aw_h_r, w_h_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [3:0] widx;
  logic do_wr;
  logic [31:0] rd_mux;
  logic [3:0] ridx;

  assign s_axi_awready = !aw_h_r;
  assign s_axi_wready = !w_h_r;
  assign s_axi_arready = !s_axi_rvalid;
  assign widx = dec(awaddr_r);
  assign ridx = dec(s_axi_araddr);
  assign do_wr = aw_h_r && w_h_r && !s_axi_bvalid;

  // Address and data capture, either order
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_h_r <= 1'b0;
      w_h_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_h_r) begin
        aw_h_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_h_r <= 1'b0;
      end
      if (s_axi_wvalid && !w_h_r) begin
        w_h_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_wr) begin
        w_h_r <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rvpa_pkg::RESP_OK;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (widx == rvpa_pkg::IDX_BAD) ? rvpa_pkg::RESP_SLVERR : rvpa_pkg::RESP_OK;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read response
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= rvpa_pkg::RESP_OK;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= (ridx == rvpa_pkg::IDX_BAD) ? rvpa_pkg::RESP_SLVERR : rvpa_pkg::RESP_OK;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ***************************************************
  // Software registers
  // ***************************************************
  logic force_r;
  logic [15:0] sp_r;
  logic [2:0] part_r;
  logic [7:0] share_r, track_r;
  logic [15:0] rate_r;
  logic [3:0] imask_r, istat_r, ev;
  logic [31:0] mg, wr_old, wr_m;
  logic part_wr;

  assign mg = merge(32'h0000_0000, wdata_r, wstrb_r);
  assign part_wr = do_wr && widx == 4'h2;

  // Current value of the addressed register, for byte merging
  always_comb begin
    wr_old = 32'h0000_0000;
    unique case (widx)
      4'h0: wr_old[rvpa_pkg::CTRL_FORCE] = force_r;
      4'h1: wr_old[15:0] = sp_r;
      4'h2: wr_old[2:0] = part_r;
      4'h5: wr_old[7:0] = share_r;
      4'h6: wr_old[7:0] = track_r;
      4'h7: wr_old[15:0] = rate_r;
      4'h9: wr_old[3:0] = imask_r;
      default: ;
    endcase
  end
  assign wr_m = merge(wr_old, wdata_r, wstrb_r);

  // Control, limits and partner bus copy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      force_r <= 1'b0;
      part_r <= 3'h0;
      share_r <= rvpa_pkg::SHARE_RST;
      track_r <= rvpa_pkg::TRACK_RST;
      rate_r <= rvpa_pkg::RATE_RST;
      imask_r <= rvpa_pkg::IMASK_RST;
    end else if (do_wr) begin
      unique case (widx)
        4'h0: force_r <= wr_m[rvpa_pkg::CTRL_FORCE];
        4'h2: part_r <= wr_m[2:0];
        4'h5: share_r <= wr_m[7:0];
        4'h6: track_r <= wr_m[7:0];
        4'h7: rate_r <= wr_m[15:0];
        4'h9: imask_r <= wr_m[3:0];
        default: ;
      endcase
    end
  end

  // Set point source selection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_r <= rvpa_pkg::SETPT_RST;
    end else if (loc_r) begin
      if (local_sp_valid) begin
        sp_r <= local_sp;
      end
    end else if (do_wr && widx == 4'h1) begin
      sp_r <= wr_m[15:0];
    end
  end
  assign setpoint = sp_r;

  // ***************************************************
  // Loop tick
  // ***************************************************
  logic [16:0] tcnt_r;
  logic tick, tick_d_r;
  assign tick = tcnt_r == 17'(LOOP_CYC - 1);

  // Loop period counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tcnt_r <= 17'h0_0000;
      tick_d_r <= 1'b0;
    end else begin
      tcnt_r <= tick ? 17'h0_0000 : tcnt_r + 17'h0_0001;
      tick_d_r <= tick;
    end
  end

  // ***************************************************
  // Partner data and watchdogs
  // ***************************************************
  logic rx_pri_r, rx_ok_r;
  logic [15:0] rx_servo_r, rx_fb_r;
  logic [3:0] swd_r, bwd_r;
  logic ser_exp, bus_exp, ser_ok, bus_alive, pfail;

  // Latch last partner link message
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_pri_r <= 1'b0;
      rx_ok_r <= 1'b0;
      rx_servo_r <= 16'h0000;
      rx_fb_r <= 16'h0000;
    end else if (link_rx_valid) begin
      rx_pri_r <= link_rx_primary;
      rx_ok_r <= link_rx_ok;
      rx_servo_r <= link_rx_servo;
      rx_fb_r <= link_rx_fb;
    end
  end

  // Link and bus watchdogs, in loop ticks
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      swd_r <= rvpa_pkg::WD_TICKS;
      bwd_r <= rvpa_pkg::WD_TICKS;
    end else begin
      if (link_rx_valid) begin
        swd_r <= 4'h0;
      end else if (tick && !ser_exp) begin
        swd_r <= swd_r + 4'h1;
      end
      if (part_wr) begin
        bwd_r <= 4'h0;
      end else if (tick && !bus_exp) begin
        bwd_r <= bwd_r + 4'h1;
      end
    end
  end
  assign ser_exp = swd_r >= rvpa_pkg::WD_TICKS;
  assign bus_exp = bwd_r >= rvpa_pkg::WD_TICKS;
  assign ser_ok = !ser_exp;
  assign bus_alive = !bus_exp && part_r[rvpa_pkg::PB_ALIVE];
  assign pfail = ser_exp && bus_exp;

  // ***************************************************
  // Own health
  // ***************************************************
  logic halt_r, coil_r, fbf_r, fb_bad, fbp_v_r;
  logic [15:0] fb_prev_r;
  logic [16:0] sum;
  logic [15:0] mn;
  logic own_ok;

  assign sum = {1'b0, sec_a} + {1'b0, sec_b};
  assign mn = (sec_a < sec_b) ? sec_a : sec_b;
  assign fb_bad = ({3'h0, mn} * 26'd100 < {1'b0, share_r} * {8'h0, sum})
    || (fbp_v_r && absdiff(fb_pos, fb_prev_r) > rate_r)
    || (ser_ok && {8'h0, absdiff(fb_pos, rx_fb_r)} * 24'd100 > {track_r, 16'h0000});
  assign own_ok = !halt_r && !coil_r && !fbf_r && !force_r;

  // Diagnostic halt and sticky fault latches
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_r <= 1'b0;
      coil_r <= 1'b0;
      fbf_r <= 1'b0;
      fb_prev_r <= 16'h0000;
      fbp_v_r <= 1'b0;
    end else begin
      if (|diag_fail) begin
        halt_r <= 1'b1;
      end
      if (coil_fault) begin
        coil_r <= 1'b1;
      end
      if (tick) begin
        fb_prev_r <= fb_pos;
        fbp_v_r <= 1'b1; // No rate check before a first sample
        if (fb_bad) begin
          fbf_r <= 1'b1;
        end
      end
    end
  end

  // ***************************************************
  // Role arbitration
  // ***************************************************
  rvpa_pkg::rvpa_role_t role_r;
  logic to_bak, to_pri;

  assign to_bak = ser_ok && bus_alive && part_r[rvpa_pkg::PB_PRI] && rx_ok_r
    && part_r[rvpa_pkg::PB_OK] && !own_ok;
  assign to_pri = own_ok && ((!bus_alive && !ser_ok)
    || (!rx_pri_r && !part_r[rvpa_pkg::PB_PRI]));

  // Evaluated once per loop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      role_r <= rvpa_pkg::ROLE_BACKUP;
    end else if (tick) begin
      unique case (role_r)
        rvpa_pkg::ROLE_PRIMARY: if (to_bak) role_r <= rvpa_pkg::ROLE_BACKUP;
        rvpa_pkg::ROLE_BACKUP: if (to_pri) role_r <= rvpa_pkg::ROLE_PRIMARY;
      endcase
    end
  end

  // ***************************************************
  // Servo drive and publication
  // ***************************************************
  logic is_pri;
  assign is_pri = role_r == rvpa_pkg::ROLE_PRIMARY;
  assign pi_run = tick && is_pri && !halt_r;
  assign servo_en = !halt_r;

  // Primary follows PI, backup replicates partner
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      servo_out <= 16'h0000;
    end else if (halt_r) begin
      servo_out <= 16'h0000;
    end else begin
      servo_out <= is_pri ? pi_out : rx_servo_r;
    end
  end

  // Link message after each role evaluation, none while halted
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_tx_valid <= 1'b0;
      link_tx_primary <= 1'b0;
      link_tx_ok <= 1'b0;
      link_tx_servo <= 16'h0000;
      link_tx_fb <= 16'h0000;
    end else begin
      link_tx_valid <= tick_d_r && !halt_r;
      if (tick_d_r) begin
        link_tx_primary <= is_pri;
        link_tx_ok <= own_ok;
        link_tx_servo <= servo_out;
        link_tx_fb <= fb_pos;
      end
    end
  end

  // ***************************************************
  // Interrupts
  // ***************************************************
  logic pfail_d_r, ok_d_r, pri_d_r, halt_d_r;

  // Edge history for events
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pfail_d_r <= 1'b1; // Watchdogs start expired, no false event
      ok_d_r <= 1'b1;
      pri_d_r <= 1'b0;
      halt_d_r <= 1'b0;
    end else begin
      pfail_d_r <= pfail;
      ok_d_r <= own_ok;
      pri_d_r <= is_pri;
      halt_d_r <= halt_r;
    end
  end
  assign ev = {halt_r && !halt_d_r, ok_d_r && !own_ok, pfail && !pfail_d_r, is_pri != pri_d_r};

  // Sticky status, write one to clear, set wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_r <= 4'h0;
    end else begin
      istat_r <= (istat_r & ~((do_wr && widx == 4'h8) ? mg[3:0] : 4'h0)) | ev;
    end
  end
  assign irq = |(istat_r & imask_r);

  // ***************************************************
  // Read mux
  // ***************************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (ridx)
      4'h0: rd_mux[rvpa_pkg::CTRL_FORCE] = force_r;
      4'h1: rd_mux[15:0] = sp_r;
      4'h2: rd_mux[2:0] = part_r;
      4'h3: rd_mux[8:0] = {loc_r, fbf_r, coil_r, pfail, bus_exp, ser_exp, halt_r, own_ok,
                           is_pri};
      4'h4: rd_mux[15:0] = servo_out;
      4'h5: rd_mux[7:0] = share_r;
      4'h6: rd_mux[7:0] = track_r;
      4'h7: rd_mux[15:0] = rate_r;
      4'h8: rd_mux[3:0] = istat_r;
      4'h9: rd_mux[3:0] = imask_r;
      default: ;
    endcase
  end

  // ***************************************************
  // Assertions
  // ***************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [16:0] gap_r;

  // Cycles since previous tick
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_r <= 17'h0_0001;
    end else begin
      gap_r <= tick ? 17'h0_0001 : gap_r + 17'h0_0001;
    end
  end

  sequence s_diag;
    |diag_fail;
  endsequence
  sequence s_halted;
    halt_r && !servo_en && servo_out == 16'h0000;
  endsequence
  sequence s_publish;
    link_tx_valid && link_tx_primary == is_pri;
  endsequence

  chk_loop_period: assert property (tick && gap_r != 17'h0_0000 && $past(tick) == 1'b0
    |-> gap_r == 17'(LOOP_CYC)) else $error("loop period wrong");
  chk_backup_replica: assert property (!is_pri && !halt_r && !$past(halt_r)
    |=> servo_out == $past(rx_servo_r)) else $error("backup not replicating");
  chk_backup_no_pi: assert property (pi_run |-> is_pri && tick)
    else $error("PI run in backup");
  chk_diag_halt: assert property (s_diag |=> ##1 s_halted [*3])
    else $error("diagnostic did not halt");
  chk_pfail_both: assert property (link_rx_valid || part_wr |=> !pfail)
    else $error("partner failed while heard");
  chk_pri_to_bak: assert property (tick && is_pri && to_bak |=> !is_pri)
    else $error("primary kept role");
  chk_bak_to_pri: assert property (tick && !is_pri && own_ok && pfail |=> is_pri)
    else $error("failover missed");
  chk_role_hold: assert property (!tick |=> $stable(role_r))
    else $error("role changed off tick");
  chk_local_sp: assert property (loc_r && local_sp_valid |=> setpoint == $past(local_sp))
    else $error("local set point lost");
  chk_tx_role: assert property (tick && !halt_r && !(|diag_fail) |=> ##1 s_publish)
    else $error("role not published");
endmodule

// File: test/rvpa_partner_model.sv
module rvpa_partner_model #(
  parameter int unsigned LOOP_CYC = 50
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic alive,
  input wire logic primary,
  input wire logic ok,
  input wire logic [15:0] servo,
  input wire logic [15:0] fb,
  output logic link_rx_valid,
  output logic link_rx_primary,
  output logic link_rx_ok,
  output logic [15:0] link_rx_servo,
  output logic [15:0] link_rx_fb
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] cnt_r;
  logic send;
  // ***************************************************
  // Own loop period, phase unrelated to the unit
  // ***************************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) cnt_r <= '0;
    else if (cnt_r == LOOP_CYC - 1) cnt_r <= '0;
    else cnt_r <= cnt_r + 32'h1;
  end
  assign send = alive && (cnt_r == 32'h7);
  // One role message per period on the dedicated line; junk between
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      link_rx_valid <= 1'h0;
      {link_rx_primary, link_rx_ok, link_rx_servo, link_rx_fb} <= '0;
    end else begin
      link_rx_valid <= send;
      if (send) {link_rx_primary, link_rx_ok, link_rx_servo, link_rx_fb} <= {primary, ok, servo, fb};
      else {link_rx_primary, link_rx_ok, link_rx_servo, link_rx_fb} <= ~{primary, ok, servo, fb};
    end
  end
endmodule

// File: test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned LC = 50;
  localparam logic [31:0] ALL = '1;
  logic ref_clk = 1'h0, rstn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, last_rd;
  logic [1:0] bresp, rresp, last_resp;
  logic local_mode_pin = 1'h0, local_sp_valid = 1'h0, coil_fault = 1'h0;
  logic [15:0] local_sp = '0, fb_pos = 16'h1000, p_servo = 16'h1234;
  logic [5:0] diag_fail = '0;
  logic p_alive = 1'h1, p_pri = 1'h1, bus_on = 1'h1, p_ok = 1'h1;
  logic [31:0] part_val = 32'h7;
  logic rxv, rxp, rxo, txv, txp, txo, pi_run, servo_en, irq;
  logic [15:0] rxs, rxf, txs, txf, setpoint, servo_out;
  int err_total = 0, checks = 0, cyc = 0, pi_last = 0, pi_gap = 0, tx_last = 0, tx_gap = 0;
  always #50 ref_clk = ~ref_clk;
  // ***************************************************
  // Unit and partner
  // ***************************************************
  rvpa_top #(.LOOP_CYC(LC)) DUT (.ref_clk(ref_clk), .rstn(rstn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .local_mode_pin(local_mode_pin), .local_sp_valid(local_sp_valid), .local_sp(local_sp),
    .diag_fail(diag_fail), .coil_fault(coil_fault), .sec_a(16'h4000), .sec_b(16'h4000),
    .fb_pos(fb_pos), .pi_out(16'h5a5a), .link_rx_valid(rxv), .link_rx_primary(rxp),
    .link_rx_ok(rxo), .link_rx_servo(rxs), .link_rx_fb(rxf), .link_tx_valid(txv),
    .link_tx_primary(txp), .link_tx_ok(txo), .link_tx_servo(txs), .link_tx_fb(txf),
    .pi_run(pi_run), .setpoint(setpoint), .servo_out(servo_out), .servo_en(servo_en),
    .irq(irq));
  rvpa_partner_model #(.LOOP_CYC(LC)) partner (.ref_clk(ref_clk), .rstn(rstn),
    .alive(p_alive), .primary(p_pri), .ok(p_ok), .servo(p_servo), .fb(16'h1000),
    .link_rx_valid(rxv), .link_rx_primary(rxp), .link_rx_ok(rxo), .link_rx_servo(rxs),
    .link_rx_fb(rxf));
  // Spacing of step requests and outgoing messages
  always @(negedge ref_clk) begin
    cyc <= cyc + 1;
    if (pi_run) begin
      pi_gap <= cyc - pi_last;
      pi_last <= cyc;
    end
    if (txv) begin
      tx_gap <= cyc - tx_last;
      tx_last <= cyc;
    end
  end
  // ***************************************************
  // Bus tasks and checks
  // ***************************************************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ag, wg, go;
    int n;
    go = 1'h0;
    n = 0;
    @(posedge ref_clk);
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'h1;
    while (!go && n < 100) begin
      @(negedge ref_clk);
      ag = awvalid & awready;
      wg = wvalid & wready;
      go = bvalid & bready;
      last_resp = bresp;
      @(posedge ref_clk);
      if (ag) awvalid <= 1'h0;
      if (wg) wvalid <= 1'h0;
      n++;
    end
    bready <= 1'h0;
    if (!go) cmp(32'h0, 32'h1);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ag, go;
    int n;
    go = 1'h0;
    n = 0;
    @(posedge ref_clk);
    arvalid <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    while (!go && n < 100) begin
      @(negedge ref_clk);
      ag = arvalid & arready;
      go = rvalid & rready;
      last_rd = rdata;
      last_resp = rresp;
      @(posedge ref_clk);
      if (ag) arvalid <= 1'h0;
      n++;
    end
    rready <= 1'h0;
    if (!go) cmp(32'h0, 32'h1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axi_rd(a);
    cmp(last_rd & m, e);
  endtask
  // Loop periods, refreshing the controller copy of partner state; only LC - 4 cycles each while bus_on is low
  task automatic ticks(input int n);
    repeat (n) begin
      if (bus_on) axi_wr(rvpa_pkg::OFS_PART, part_val);
      repeat (LC - 4) @(posedge ref_clk);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ***************************************************
  // Scenarios
  // ***************************************************
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'h1;
    repeat (3) @(posedge ref_clk);
    rdc(rvpa_pkg::OFS_SHARE, ALL, 32'h0a);
    rdc(rvpa_pkg::OFS_TRACK, ALL, 32'h01);
    rdc(rvpa_pkg::OFS_RATE, ALL, 32'h800);
    axi_rd(8'h30);
    cmp(last_resp, rvpa_pkg::RESP_SLVERR);
    axi_wr(8'h30, ALL);
    cmp(last_resp, rvpa_pkg::RESP_SLVERR);
    axi_wr(rvpa_pkg::OFS_SETPT, 32'habcd);
    cmp(setpoint, 32'habcd);
    local_mode_pin <= 1'h1;
    local_sp <= 16'h2222;
    repeat (4) @(posedge ref_clk);
    local_sp_valid <= 1'h1;
    @(posedge ref_clk);
    local_sp_valid <= 1'h0;
    axi_wr(rvpa_pkg::OFS_SETPT, 32'h1111);
    cmp(setpoint, 32'h2222);
    rdc(rvpa_pkg::OFS_STAT, 32'h100, 32'h100);
    local_mode_pin <= 1'h0;
    // Backup follows the partner's drive
    ticks(3);
    p_servo <= 16'h4321;
    ticks(2);
    rdc(rvpa_pkg::OFS_STAT, 32'h1, 32'h0);
    cmp(servo_out, 32'h4321);
    cmp(pi_last, 32'h0);
    cmp(txp, 32'h0);
    cmp(txs, 32'h4321);
    cmp({txo, txf}, 32'h1_1000);
    // Partner reports backup on both paths
    p_pri <= 1'h0;
    part_val = 32'h5;
    ticks(4);
    rdc(rvpa_pkg::OFS_STAT, 32'h3, 32'h3);
    cmp(servo_out, 32'h5a5a);
    cmp(pi_gap, LC);
    cmp(tx_gap, LC);
    cmp(txp, 32'h1);
    cmp(irq, 32'h0);
    axi_wr(rvpa_pkg::OFS_IMASK, 32'h1);
    cmp(irq, 32'h1);
    axi_wr(rvpa_pkg::OFS_ISTAT, 32'h1);
    cmp(irq, 32'h0);
    rdc(rvpa_pkg::OFS_ISTAT, 32'h1, 32'h0);
    // Own fault, partner primary but unhealthy on the link, then healthy
    p_pri <= 1'h1;
    p_ok <= 1'h0;
    part_val = 32'h7;
    ticks(2);
    axi_wr(rvpa_pkg::OFS_CTRL, 32'h1);
    ticks(3);
    rdc(rvpa_pkg::OFS_STAT, 32'h3, 32'h1);
    p_ok <= 1'h1;
    ticks(3);
    rdc(rvpa_pkg::OFS_STAT, 32'h3, 32'h0);
    cmp(irq, 32'h1);
    // Link silent only, then bus silent too
    axi_wr(rvpa_pkg::OFS_CTRL, 32'h0);
    p_alive <= 1'h0;
    ticks(4);
    rdc(rvpa_pkg::OFS_STAT, 32'h29, 32'h08);
    bus_on = 1'h0;
    ticks(5);
    rdc(rvpa_pkg::OFS_STAT, 32'h39, 32'h39);
    // Coil fault while primary
    p_alive <= 1'h1;
    bus_on = 1'h1;
    coil_fault <= 1'h1;
    ticks(4);
    rdc(rvpa_pkg::OFS_STAT, 32'h41, 32'h40);
    fb_pos <= 16'h3000;
    ticks(2);
    rdc(rvpa_pkg::OFS_STAT, 32'h80, 32'h80);
    diag_fail <= 6'h01;
    repeat (3) @(posedge ref_clk);
    cmp(servo_en, 32'h0);
    cmp(servo_out, 32'h0);
    rdc(rvpa_pkg::OFS_STAT, 32'h4, 32'h4);
    give_verdict;
  end
  // Hang guard
  initial begin
    #1_000_000;
    err_total++;
    give_verdict;
  end
endmodule
